// [verilog/wss_pkg.sv]
// wss_pkg: constants for the windowed service supervisor
// assumes a 50 MHz core clock and an idle-tick strobe from the timer
package wss_pkg;
  // register map (word offsets as byte addresses)
  localparam logic [3:0] ADDR_SERVICE = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;

  // service register fields
  localparam int WIN_HI = 7;
  localparam int WIN_LO = 6;
  localparam int KEY_HI = 5;
  localparam int KEY_LO = 1;
  localparam int CMON_BIT = 0;
  localparam logic [4:0] KEY_VALUE = 5'h0C;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic       CMON_RESET = 1'b1;

  // status register fields
  localparam int ST_FAULT  = 0;
  localparam int ST_CMON   = 1;
  localparam int ST_CONFIG = 2;
  localparam int ST_BOOT   = 3;

  // control register fields
  localparam int CT_OPT_DIS = 0;
  localparam int CT_BOOT    = 1;

  // window timing in idle ticks
  localparam logic [16:0] LOWER_TICKS = 17'h00800;
  localparam logic [16:0] UPPER_8K    = 17'h02000;

  // fault hold after pin falls: 16 to 32 cycles, we use 24
  localparam logic [5:0] FAULT_HOLD = 6'h18;

  // clock monitor: core cycles per instruction cycle at the 5 kHz limit
  localparam int CMON_MIN_HZ   = 5000;
  localparam int CLK_HZ        = 50000000;
  localparam int CMON_TIMEOUT  = CLK_HZ / CMON_MIN_HZ;
endpackage : wss_pkg

// [verilog/wss_sync.sv]
// wss_sync: two-stage synchroniser for pin-side levels
// assumes the input is asynchronous to core_clk
`timescale 1ns/100ps
module wss_sync (
  // clock
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic out_nxt;

  always_comb begin
    meta_nxt = async_in;
    out_nxt  = meta_r;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r   <= 1'b1;
      sync_out <= 1'b1;
    end else if (clk_en) begin
      meta_r   <= meta_nxt;
      sync_out <= out_nxt;
    end
  end
endmodule : wss_sync

// [verilog/wss_clkmon.sv]
// wss_clkmon: flags an instruction clock slower than the minimum rate
// assumes tc_tick is a synchronised one-cycle strobe per instruction cycle
`timescale 1ns/100ps
module wss_clkmon #(
  parameter int TIMEOUT = wss_pkg::CMON_TIMEOUT
) (
  // clock
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // monitor
  input  wire logic enable,
  input  wire logic tc_tick,
  output logic      clk_err
);
  logic [17:0] cnt_r;
  logic [17:0] cnt_nxt;
  logic        err_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    err_nxt = clk_err;
    if (!enable || tc_tick) begin
      cnt_nxt = '0;
      err_nxt = 1'b0;
    end else if (cnt_r >= 18'(TIMEOUT)) begin
      err_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 18'h00001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r   <= '0;
      clk_err <= 1'b0;
    end else if (clk_en) begin
      cnt_r   <= cnt_nxt;
      clk_err <= err_nxt;
    end
  end
endmodule : wss_clkmon

// [verilog/wss_supervisor.sv]
// wss_supervisor: windowed service supervisor with clock-rate monitor
// assumes an Avalon-MM master on core_clk and pin levels from outside
`timescale 1ns/100ps
module wss_supervisor #(
  parameter int CMON_TIMEOUT = wss_pkg::CMON_TIMEOUT
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // timing sources
  input  wire logic        idle_tick,
  input  wire logic        tc_tick_pin,
  // fault pin, active low open drain
  input  wire logic        fault_output_pin_in,
  output logic             fault_output_pin_out,
  output logic             fault_output_pin_oe
);
  typedef enum logic [3:0] {
    WSS_OFF   = 4'h1,
    WSS_RUN   = 4'h2,
    WSS_DRIVE = 4'h4,
    WSS_WAIT  = 4'h8
  } wss_state_e;

  // upper bound in idle ticks from the window select
  function automatic logic [16:0] upper_of(input logic [1:0] win);
    upper_of = wss_pkg::UPPER_8K << win;
  endfunction : upper_of

  // field decode of a service byte
  function automatic logic [1:0] win_of(input logic [7:0] d);
    win_of = d[wss_pkg::WIN_HI:wss_pkg::WIN_LO];
  endfunction : win_of

  function automatic logic [4:0] key_of(input logic [7:0] d);
    key_of = d[wss_pkg::KEY_HI:wss_pkg::KEY_LO];
  endfunction : key_of

  function automatic logic cmon_of(input logic [7:0] d);
    cmon_of = d[wss_pkg::CMON_BIT];
  endfunction : cmon_of

  wss_state_e  state_r, state_nxt;
  logic [1:0]  win_r, win_nxt;
  logic        cmon_en_r, cmon_en_nxt;
  logic        cfg_done_r, cfg_done_nxt;
  logic        opt_dis_r, opt_dis_nxt;
  logic        boot_r, boot_nxt;
  logic [16:0] tick_cnt_r, tick_cnt_nxt;
  logic [5:0]  hold_r, hold_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_nxt;
  logic        pin_s;
  logic        tc_s, tc_d_r;
  logic        clk_err;
  logic        req;
  logic        svc_wr;
  logic        key_ok;
  logic        full_ok;
  logic [7:0]  wd;
  logic        tc_d_nxt;
  logic        ctl_wr;
  logic        boot_edge;
  logic        early;
  logic        upper_exp;
  logic        cfg_take;
  logic        svc_take;
  logic        fault_set;
  logic        back_to_run;

  wss_sync u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (fault_output_pin_in),
    .sync_out (pin_s)
  );

  wss_sync u_tc_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (tc_tick_pin),
    .sync_out (tc_s)
  );

  wss_clkmon #(
    .TIMEOUT (CMON_TIMEOUT)
  ) u_clkmon (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .enable   (cmon_en_r && !opt_dis_r),
    .tc_tick  (tc_s && !tc_d_r),
    .clk_err  (clk_err)
  );

  // one wait state per access, answer in the second cycle
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_r;
  assign wd              = avs_writedata[7:0];
  assign svc_wr = avs_write && ack_r &&
                  avs_address == wss_pkg::ADDR_SERVICE;
  assign key_ok    = key_of(wd) == wss_pkg::KEY_VALUE;
  assign full_ok   = key_ok && win_of(wd) == win_r &&
                     cmon_of(wd) == cmon_en_r;
  assign ctl_wr    = avs_write && ack_r &&
                     avs_address == wss_pkg::ADDR_CONTROL;
  assign boot_edge = ctl_wr &&
                     avs_writedata[wss_pkg::CT_BOOT] != boot_r;
  assign early     = !boot_r && tick_cnt_r < wss_pkg::LOWER_TICKS;
  assign upper_exp = tick_cnt_r >= upper_of(win_r);

  // service decision, only while running; writes during a fault drop
  always_comb begin
    cfg_take    = 1'b0;
    svc_take    = 1'b0;
    fault_set   = 1'b0;
    back_to_run = 1'b0;
    if (state_r == WSS_RUN && !opt_dis_r) begin
      if (clk_err) begin
        fault_set = 1'b1;
      end else if (svc_wr && !cfg_done_r) begin
        if (key_ok) begin
          cfg_take = 1'b1;
        end else begin
          fault_set = 1'b1;
        end
      end else if (svc_wr) begin
        if (!full_ok || early) begin
          fault_set = 1'b1;
        end else begin
          svc_take = 1'b1;
        end
      end else if (upper_exp) begin
        fault_set = 1'b1;
      end
    end
    if (state_r == WSS_WAIT && hold_r == 6'h00 && !clk_err && pin_s) begin
      back_to_run = 1'b1;
    end
  end

  // bus group: one wait state, read data registered
  always_comb begin
    ack_nxt   = req && !ack_r;
    rdata_nxt = avs_readdata;
    if (avs_read && !ack_r) begin
      case (avs_address)
        wss_pkg::ADDR_SERVICE:
          rdata_nxt = {24'h000000, win_r, 5'h00, cmon_en_r};
        wss_pkg::ADDR_STATUS:
          rdata_nxt = {28'h0000000, boot_r, cfg_done_r, clk_err,
                       state_r == WSS_DRIVE || state_r == WSS_WAIT};
        wss_pkg::ADDR_CONTROL:
          rdata_nxt = {30'h00000000, boot_r, opt_dis_r};
        default:
          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r        <= 1'b0;
      avs_readdata <= '0;
    end else if (clk_en) begin
      ack_r        <= ack_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // configuration group: option, boot mode, one-time setup
  always_comb begin
    win_nxt      = win_r;
    cmon_en_nxt  = cmon_en_r;
    cfg_done_nxt = cfg_done_r;
    opt_dis_nxt  = opt_dis_r;
    boot_nxt     = boot_r;
    if (ctl_wr) begin
      opt_dis_nxt = avs_writedata[wss_pkg::CT_OPT_DIS];
      boot_nxt    = avs_writedata[wss_pkg::CT_BOOT];
    end
    if (cfg_take) begin
      win_nxt      = win_of(wd);
      cmon_en_nxt  = cmon_of(wd);
      cfg_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_r      <= wss_pkg::WIN_RESET;
      cmon_en_r  <= wss_pkg::CMON_RESET;
      cfg_done_r <= 1'b0;
      opt_dis_r  <= 1'b0;
      boot_r     <= 1'b0;
    end else if (clk_en) begin
      win_r      <= win_nxt;
      cmon_en_r  <= cmon_en_nxt;
      cfg_done_r <= cfg_done_nxt;
      opt_dis_r  <= opt_dis_nxt;
      boot_r     <= boot_nxt;
    end
  end

  // window counter in idle ticks, saturating; restarts win over ticks
  always_comb begin
    tick_cnt_nxt = tick_cnt_r;
    if (idle_tick && tick_cnt_r != 17'h1FFFF) begin
      tick_cnt_nxt = tick_cnt_r + 17'h00001;
    end
    if (boot_edge) begin
      tick_cnt_nxt = '0;
    end
    if (state_r == WSS_OFF || cfg_take || svc_take || back_to_run) begin
      tick_cnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // rising edge of the synchronised instruction clock
  always_comb begin
    tc_d_nxt = tc_s;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tc_d_r <= 1'b1; // same as synchroniser reset: no false edge
    end else if (clk_en) begin
      tc_d_r <= tc_d_nxt;
    end
  end

  // fault state machine and pin hold counter
  always_comb begin
    state_nxt = state_r;
    hold_nxt  = hold_r;
    case (state_r)
      WSS_OFF: begin
        if (!opt_dis_r) state_nxt = WSS_RUN;
      end
      WSS_RUN: begin
        if (opt_dis_r) begin
          state_nxt = WSS_OFF;
        end else if (fault_set) begin
          state_nxt = WSS_DRIVE;
        end
      end
      WSS_DRIVE: begin
        hold_nxt = wss_pkg::FAULT_HOLD;
        if (!pin_s) state_nxt = WSS_WAIT;
      end
      WSS_WAIT: begin
        if (clk_err) begin
          hold_nxt = wss_pkg::FAULT_HOLD;
        end else if (hold_r != 6'h00) begin
          hold_nxt = hold_r - 6'h01;
        end else if (back_to_run) begin
          state_nxt = WSS_RUN; // window restarts once the pin is high
        end
      end
      default: state_nxt = WSS_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= WSS_OFF;
      hold_r  <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
    end
  end

  // open drain: the pin is only ever pulled low
  assign fault_output_pin_out = 1'b0;
  assign fault_output_pin_oe  = state_r == WSS_DRIVE ||
                                (state_r == WSS_WAIT && hold_r != 6'h00);
endmodule : wss_supervisor

// [tb/wss_supervisor_checker.sv]
// wss_supervisor_checker: port assertions for wss_supervisor
// assumes no bus request is made while clk_en is low
`timescale 1ns/100ps
module wss_supervisor_checker #(
  parameter int CMON_TIMEOUT = 50
) (
  // clock
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        idle_tick,
  input wire logic        tc_tick_pin,
  input wire logic        fault_output_pin_in,
  input wire logic        fault_output_pin_out,
  input wire logic        fault_output_pin_oe
);
  wire rd_done = avs_read && !avs_waitrequest;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_held16;
    fault_output_pin_oe [*8] ##1 fault_output_pin_oe [*8];
  endsequence
  a_wait_one:
    assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_idle_ready:
    assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_reset_quiet:
    assert property ($fell(rst) |->
      !fault_output_pin_oe && avs_readdata == 32'h0)
    else $error("fault or data left over from reset");
  a_pin_low:
    assert property (fault_output_pin_out == 1'b0)
    else $error("fault pin drives high");
  a_key_hidden:
    assert property (rd_done && avs_address == wss_pkg::ADDR_SERVICE
      |-> avs_readdata[5:1] == 5'h00)
    else $error("key readable");
  a_unmapped_zero:
    assert property (rd_done && !(avs_address inside {4'h0, 4'h4, 4'h8})
      |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_hold_min:
    assert property ($fell(fault_output_pin_in) && fault_output_pin_oe
      |=> s_held16)
    else $error("fault released early");
  a_release_late:
    assert property ($fell(fault_output_pin_oe) |->
      !$past(fault_output_pin_in, 16))
    else $error("released before pin low long enough");
endmodule : wss_supervisor_checker

// [tb/tb.sv]
// tb: self-checking bench for wss_supervisor
// assumes one idle tick per clock and models the pin pull-up here
`timescale 1ns/100ps
module tb;
  localparam int CMT = 50;
  logic        core_clk, rst, clk_en, avs_read, avs_write, idle_tick;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic        avs_waitrequest, tc_run;
  logic        tc_tick_pin = 1'b0;
  logic        fault_output_pin_in = 1'b1;
  logic        fault_output_pin_out, fault_output_pin_oe;
  logic [1:0]  tc_div = 2'h0;
  logic [7:0]  bad [4];
  int          mismatches, compares, n;

  wss_supervisor #(.CMON_TIMEOUT(CMT)) dut_u (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_tick(idle_tick), .tc_tick_pin(tc_tick_pin),
    .fault_output_pin_in(fault_output_pin_in),
    .fault_output_pin_out(fault_output_pin_out),
    .fault_output_pin_oe(fault_output_pin_oe));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // pull-up: pin reads low only while the device drives it
  always @(posedge core_clk) begin
    fault_output_pin_in <= (fault_output_pin_oe === 1'b1) ?
                           fault_output_pin_out : 1'b1;
    tc_div <= tc_div + 2'h1;
    tc_tick_pin <= tc_run & tc_div[1];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] svc(input logic [1:0] w, input logic m);
    return {w, wss_pkg::KEY_VALUE, m};
  endfunction : svc

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, logic [7:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    if (k == 20) begin
      chk("bus_answer", 32'h0, 32'h1);
      close_out();
    end
  endtask : bus

  task automatic wait_oe(input logic lvl, input int lim);
    for (n = 0; n < lim && fault_output_pin_oe !== lvl; n++)
      @(posedge core_clk);
    chk("fault_oe", 32'(lvl), 32'(fault_output_pin_oe));
    if (fault_output_pin_oe !== lvl) close_out();
  endtask : wait_oe

  task automatic recover();
    wait_oe(1'b0, 2000);
    repeat (2200) @(posedge core_clk);
  endtask : recover

  initial begin
    rst = 1'b1; clk_en = 1'b1; idle_tick = 1'b1; tc_run = 1'b1;
    avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; r = 32'h4CA5;
    mismatches = 0; compares = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, wss_pkg::ADDR_SERVICE, 8'h00);
    chk("svc_reset", {24'h0, svc(2'h3, 1'b1) & 8'hC1}, q);
    bus(1'b0, wss_pkg::ADDR_STATUS, 8'h00);
    chk("status_reset", 32'h0, q & 32'h3);
    bus(1'b0, 4'hC, 8'h00);
    chk("unmapped", 32'h0, q);
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h2, 1'b0));
    recover();
    bus(1'b0, wss_pkg::ADDR_SERVICE, 8'h00);
    chk("svc_fixed", {24'h0, svc(2'h0, 1'b1) & 8'hC1}, q);
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
    repeat (3) begin
      r = lfsr(r);
      repeat (2100 + r % 5000) @(posedge core_clk);
      bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
      chk("no_fault", 32'h0, 32'(fault_output_pin_oe));
    end
    wait_oe(1'b1, 9000);
    chk("upper", 32'h1, 32'(n > 8150 && n < 8250));
    wait_oe(1'b0, 300);
    chk("hold", 32'h1, 32'(n > 17 && n < 45));
    repeat (2200) @(posedge core_clk);
    r = lfsr(r);
    bad = '{svc(2'h0, 1'b1), svc(2'h1, 1'b1),
            {2'h0, wss_pkg::KEY_VALUE ^ (r[4:0] | 5'h01), 1'b1},
            svc(2'h0, 1'b0)};
    foreach (bad[i]) begin
      if (i == 0) begin
        bus(1'b1, wss_pkg::ADDR_SERVICE, bad[0]);
        repeat (100) @(posedge core_clk);
      end
      bus(1'b1, wss_pkg::ADDR_SERVICE, bad[i]);
      wait_oe(1'b1, 10);
      recover();
    end
    tc_run <= 1'b0;
    wait_oe(1'b1, 400);
    bus(1'b0, wss_pkg::ADDR_STATUS, 8'h00);
    chk("clk_err", 32'h1, 32'(q[wss_pkg::ST_CMON]));
    tc_run <= 1'b1;
    recover();
    bus(1'b1, wss_pkg::ADDR_CONTROL, 8'h02);
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
    chk("boot_svc", 32'h0, 32'(fault_output_pin_oe));
    bus(1'b1, wss_pkg::ADDR_CONTROL, 8'h00);
    repeat (2200) @(posedge core_clk);
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
    repeat (30) @(posedge core_clk);
    chk("boot_quiet", 32'h0, 32'(fault_output_pin_oe));
    clk_en <= 1'b0;
    repeat (9000) @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("frozen", 32'h0, 32'(fault_output_pin_oe));
    bus(1'b1, wss_pkg::ADDR_SERVICE, svc(2'h0, 1'b1));
    wait_oe(1'b1, 10);
    recover();
    bus(1'b1, wss_pkg::ADDR_CONTROL, 8'h01);
    repeat (9000) @(posedge core_clk);
    chk("disabled", 32'h0, 32'(fault_output_pin_oe));
    close_out();
  end

  initial begin
    repeat (99000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
endmodule : tb

bind wss_supervisor wss_supervisor_checker #(
  .CMON_TIMEOUT(CMON_TIMEOUT)) chk_u (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .idle_tick(idle_tick), .tc_tick_pin(tc_tick_pin),
  .fault_output_pin_in(fault_output_pin_in),
  .fault_output_pin_out(fault_output_pin_out),
  .fault_output_pin_oe(fault_output_pin_oe));
